/* common/qbs_pkg.sv */
// shared constants and types of the burst sram port
package qbs_pkg;
   localparam int ADDR_W = 20; // burst addresses
   localparam int DATA_W = 18; // word width
   localparam int BEAT_W = 2; // four words per burst
   localparam int LOW_MSB = 8; // lower byte is bits 8..0
   localparam int LAT_HI = 5; // 2.5 cycles in half edges
   localparam int LAT_LO = 2; // 1 cycle in half edges
   localparam int SCHED_N = 8; // read launch slots
   localparam int FIFO_DEPTH = 16;
   localparam logic [2:0] BURST_LEN = 3'h4;
   localparam logic [2:0] PTR_ZERO = 3'h0;

   // all pins that enter through the synchroniser
   typedef struct packed {
      logic k;
      logic kn;
      logic rps_n;
      logic wps_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] d;
      logic [1:0] bws_n;
      logic mode;
   } qbs_pins_t;

   // one scheduled read word
   typedef struct packed {
      logic vld;
      logic [ADDR_W-1:0] addr;
      logic [BEAT_W-1:0] beat;
   } qbs_slot_t;

   // one write word on its way to the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BEAT_W-1:0] beat;
      logic [1:0] bws_n;
      logic [DATA_W-1:0] data;
   } qbs_wword_t;

   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_BEAT1 = 2'b01,
      WS_BEAT2 = 2'b10,
      WS_BEAT3 = 2'b11
   } qbs_wstate_t;
endpackage

/* verilog/qbs_sram_port.sv */
// burst sram port: synchroniser, write fifo, array and read pipeline
//
// Contract
// - separate read data outputs and write data inputs, no turnaround.
// - one shared address bus, read and write addresses on alternate K edges.
// - each address holds four consecutive 18-bit words moved as one burst.
// - a burst word moves on every rising edge of K and K-bar.
// - read and write bursts proceed independently and may overlap.
// - latency mode high gives read data 2.5 cycles after the command.
// - latency mode low gives read data one cycle after the command.
// - read valid flag marks cycles carrying valid read burst data.
// - separate read and write selects allow depth expansion.
// - every synchronous input is registered before internal use.
// - every read data output comes from an output register.
// - array writes complete internally, no external write pulse timing.
// - a complementary echo clock pair accompanies read data.
// - reads return newest data, including writes still pending inside.
// - only rising edges of K and K-bar act; falling edges are ignored.
// - write select sampled at K rise starts a burst; else data ignored.
// - byte selects per word gate bits 8..0 and 17..9; others kept.
// - read outputs go high impedance while the read port is idle; this port only drops q_oe_out, and q_out keeps its last value.
`timescale 1ns/1ps

module qbs_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] store [0:DEPTH-1];
   logic [PW:0] wr_ptr;
   logic [PW:0] rd_ptr;
   logic [PW:0] next_wr_ptr;
   logic [PW:0] next_rd_ptr;
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   always_comb begin
      in_ready_out = (wr_ptr[PW] == rd_ptr[PW]) ||
                     (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
      out_valid_out = (wr_ptr != rd_ptr);
      out_data_out = store[rd_ptr[PW-1:0]];
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   // pointer registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk_in) begin
      if (push) begin
         store[wr_ptr[PW-1:0]] <= in_data_in;
      end
   end
endmodule

module qbs_sram_port import qbs_pkg::*; #(
   parameter int MEM_AW = ADDR_W
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic k_in,
   input wire logic k_n_in,
   input wire logic read_port_select_n_in,
   input wire logic write_port_select_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] d_in,
   input wire logic [1:0] byte_write_select_n_in,
   input wire logic latency_mode_pin_in,
   output logic [DATA_W-1:0] q_out,
   output logic q_oe_out,
   output logic read_valid_flag_out,
   output logic echo_clock_out,
   output logic echo_clock_n_out,
   output logic wr_ready_out
);
   localparam int MI = MEM_AW + BEAT_W;
   logic [DATA_W-1:0] mem [0:(2**MI)-1];
   qbs_pins_t pin_raw;
   qbs_pins_t sync1;
   qbs_pins_t sync2;
   logic k_prev;
   logic kn_prev;
   logic ek;
   logic ekn;
   logic ev;
   qbs_slot_t sched [0:SCHED_N-1];
   qbs_slot_t next_sched [0:SCHED_N-1];
   qbs_slot_t launch;
   logic rd_cmd;
   logic rd_pend;
   logic next_rd_pend;
   logic [MI-1:0] rd_idx;
   logic [MI-1:0] next_rd_idx;
   logic rd_load;
   logic wr_busy;
   logic [DATA_W-1:0] next_q;
   logic next_valid;
   qbs_wstate_t wstate;
   qbs_wstate_t next_wstate;
   logic [DATA_W-1:0] stage_d [0:3];
   logic [1:0] stage_b [0:3];
   logic [DATA_W-1:0] next_stage_d [0:3];
   logic [1:0] next_stage_b [0:3];
   logic [ADDR_W-1:0] waddr;
   logic [ADDR_W-1:0] next_waddr;
   logic addr_ok;
   logic next_addr_ok;
   logic [2:0] got;
   logic [2:0] next_got;
   logic [2:0] push_idx;
   logic [2:0] next_push_idx;
   logic cap;
   qbs_wword_t fin;
   qbs_wword_t fout;
   logic fin_valid;
   logic fin_ready;
   logic fout_valid;
   logic drain;
   logic [MI-1:0] dr_idx;
   logic [DATA_W-1:0] dr_old;
   logic [DATA_W-1:0] dr_new;
   logic [3:0] rd_cnt;
   logic [3:0] next_rd_cnt;
   logic [3:0] rd_done;
   logic [3:0] next_rd_done;
   logic [3:0] wtag;
   logic [3:0] next_wtag;
   logic [3:0] ftag;
   logic [$bits(qbs_wword_t)+3:0] fraw;

   // true once every read taken before a write has fetched its burst
   function automatic logic older(input logic [3:0] done,
      input logic [3:0] tag);
      logic [3:0] gap;
      gap = done - tag;
      return !gap[3];
   endfunction

   // two flip-flops on every pin before any logic looks at it
   assign pin_raw = '{k: k_in, kn: k_n_in, rps_n: read_port_select_n_in,
      wps_n: write_port_select_n_in, addr: addr_in, d: d_in,
      bws_n: byte_write_select_n_in, mode: latency_mode_pin_in};
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1 <= '0;
         sync2 <= '0;
         k_prev <= 1'b0;
         kn_prev <= 1'b0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         k_prev <= sync2.k;
         kn_prev <= sync2.kn;
      end
   end

   // rising edges only; falling edges produce no event
   assign ek = sync2.k && !k_prev;
   assign ekn = sync2.kn && !kn_prev;
   assign ev = ek || ekn;
   assign rd_cmd = ek && !sync2.rps_n;

   // read scheduler: each slot moves one half edge closer to launch
   always_comb begin
      launch = sched[0];
      for (int i = 0; i < SCHED_N; i++) begin
         next_sched[i] = sched[i];
      end
      if (ev) begin
         for (int i = 0; i < SCHED_N - 1; i++) begin
            next_sched[i] = sched[i + 1];
         end
         next_sched[SCHED_N-1] = '0;
         if (rd_cmd) begin
            for (int b = 0; b < 4; b++) begin
               next_sched[(sync2.mode ? LAT_HI : LAT_LO) - 1 + b] =
                  '{vld: 1'b1, addr: sync2.addr, beat: BEAT_W'(b)};
            end
         end
      end
   end

   // read order counters: commands taken and bursts fully fetched
   always_comb begin
      next_rd_cnt = rd_cnt + 4'(rd_cmd);
      next_rd_done = rd_done;
      if (rd_load && rd_idx[BEAT_W-1:0] == 2'h3) begin
         next_rd_done = rd_done + 4'h1;
      end
   end

   // a fetch waits only for writes commanded before its read
   assign wr_busy = (fout_valid && older(rd_done, ftag)) ||
      (addr_ok && push_idx < got && older(rd_done, wtag));
   assign rd_load = rd_pend && !wr_busy;
   always_comb begin
      next_rd_pend = rd_pend && !rd_load;
      next_rd_idx = rd_idx;
      next_q = q_out;
      next_valid = read_valid_flag_out;
      if (rd_load) begin
         next_q = mem[rd_idx];
         next_valid = 1'b1;
      end
      if (ev) begin
         next_rd_pend = launch.vld;
         next_rd_idx = MI'({launch.addr, launch.beat});
         next_valid = 1'b0;
      end
   end

   // read output registers and echo clocks
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < SCHED_N; i++) begin
            sched[i] <= '0;
         end
         rd_pend <= 1'b0;
         rd_cnt <= '0;
         rd_done <= '0;
         rd_idx <= '0;
         q_out <= '0;
         read_valid_flag_out <= 1'b0;
         echo_clock_out <= 1'b0;
         echo_clock_n_out <= 1'b0;
      end else begin
         for (int i = 0; i < SCHED_N; i++) begin
            sched[i] <= next_sched[i];
         end
         rd_pend <= next_rd_pend;
         rd_cnt <= next_rd_cnt;
         rd_done <= next_rd_done;
         rd_idx <= next_rd_idx;
         q_out <= next_q;
         read_valid_flag_out <= next_valid;
         echo_clock_out <= sync2.k;
         echo_clock_n_out <= sync2.kn;
      end
   end
   assign q_oe_out = read_valid_flag_out;

   // write burst: word on each half edge, address on the second K rise
   always_comb begin
      next_wstate = wstate;
      cap = 1'b0;
      next_waddr = waddr;
      next_addr_ok = addr_ok;
      next_wtag = wtag;
      case (wstate)
         WS_IDLE: begin
            if (ek && !sync2.wps_n) begin
               cap = 1'b1;
               next_wtag = next_rd_cnt; // reads taken so far are older
               next_addr_ok = 1'b0;
               next_wstate = WS_BEAT1;
            end
         end
         WS_BEAT1: begin
            if (ekn) begin
               cap = 1'b1;
               next_wstate = WS_BEAT2;
            end
         end
         WS_BEAT2: begin
            if (ek) begin
               cap = 1'b1;
               next_waddr = sync2.addr;
               next_addr_ok = 1'b1;
               next_wstate = WS_BEAT3;
            end
         end
         WS_BEAT3: begin
            if (ekn) begin
               cap = 1'b1;
               next_wstate = WS_IDLE;
            end
         end
         default: next_wstate = WS_IDLE;
      endcase
   end

   // staging holds the words until the address is known
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_stage_d[i] = stage_d[i];
         next_stage_b[i] = stage_b[i];
      end
      next_got = got;
      next_push_idx = push_idx;
      if (fin_valid && fin_ready) begin
         next_push_idx = push_idx + 3'h1;
      end
      if (cap) begin
         next_stage_d[wstate] = sync2.d;
         next_stage_b[wstate] = sync2.bws_n;
         next_got = (wstate == WS_IDLE) ? 3'h1 : got + 3'h1;
         if (wstate == WS_IDLE) begin
            next_push_idx = PTR_ZERO;
         end
      end
   end
   assign fin_valid = addr_ok && (push_idx < got) && (got <= BURST_LEN);
   assign fin = '{addr: waddr, beat: push_idx[BEAT_W-1:0],
      bws_n: stage_b[push_idx[BEAT_W-1:0]],
      data: stage_d[push_idx[BEAT_W-1:0]]};
   assign wr_ready_out = fin_ready;

   // write side registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wstate <= WS_IDLE;
         waddr <= '0;
         wtag <= '0;
         addr_ok <= 1'b0;
         got <= '0;
         push_idx <= '0;
         for (int i = 0; i < 4; i++) begin
            stage_d[i] <= '0;
            stage_b[i] <= 2'h3;
         end
      end else begin
         wstate <= next_wstate;
         waddr <= next_waddr;
         wtag <= next_wtag;
         addr_ok <= next_addr_ok;
         got <= next_got;
         push_idx <= next_push_idx;
         for (int i = 0; i < 4; i++) begin
            stage_d[i] <= next_stage_d[i];
            stage_b[i] <= next_stage_b[i];
         end
      end
   end

   // each fifo word carries the read count of its write command
   qbs_fifo #(.W($bits(qbs_wword_t) + 4), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .in_valid_in(fin_valid),
      .in_ready_out(fin_ready),
      .in_data_in({wtag, fin}),
      .out_valid_out(fout_valid),
      .out_ready_in(drain),
      .out_data_out(fraw)
   );
   assign fout = fraw[$bits(qbs_wword_t)-1:0];
   assign ftag = fraw[$bits(qbs_wword_t)+3 -: 4];

   // self-timed array write; waits for older reads and any fetch cycle
   assign drain = fout_valid && !rd_load &&
      older(rd_done, ftag);
   assign dr_idx = MI'({fout.addr, fout.beat});
   assign dr_old = mem[dr_idx];
   always_comb begin
      dr_new = dr_old;
      if (!fout.bws_n[0]) begin
         dr_new[LOW_MSB:0] = fout.data[LOW_MSB:0];
      end
      if (!fout.bws_n[1]) begin
         dr_new[DATA_W-1:LOW_MSB+1] = fout.data[DATA_W-1:LOW_MSB+1];
      end
   end
   always_ff @(posedge clk_in) begin
      if (drain) begin
         mem[dr_idx] <= dr_new;
      end
   end

   // checks
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   AST_OE_WITH_VALID: assert property (
      (q_oe_out == read_valid_flag_out) and
      (!ev |=> ($stable(q_oe_out) || $rose(q_oe_out))))
      else $error("read outputs enabled without valid data");
   AST_LAT_HIGH: assert property (
      rd_cmd && sync2.mode |=> sched[LAT_HI-1].vld &&
      sched[LAT_HI-1].beat == 2'h0 && sched[LAT_HI+2].beat == 2'h3)
      else $error("long latency slot misplaced");
   AST_LAT_LOW: assert property (
      rd_cmd && !sync2.mode |=> sched[LAT_LO-1].vld &&
      sched[LAT_LO-1].addr == $past(sync2.addr))
      else $error("short latency slot misplaced");
   AST_VALID_LOAD: assert property (
      rd_load && !ev |=> read_valid_flag_out && q_out == $past(mem[rd_idx]))
      else $error("valid flag not raised with fetched data");
   AST_FETCH_BOUND: assert property (
      $rose(rd_pend) |-> ##[0:60] !rd_pend)
      else $error("read fetch starved by writes");
   AST_NO_FALL_ACTION: assert property (
      !ev && !rd_load |=> $stable(read_valid_flag_out) && $stable(q_out))
      else $error("read port changed without a rising edge");
   AST_WPS_IGNORED: assert property (
      wstate == WS_IDLE && !(ek && !sync2.wps_n) |=> wstate == WS_IDLE)
      else $error("write burst started without select");
   AST_BYTE_KEEP: assert property (
      drain && fout.bws_n[0] |=> mem[$past(dr_idx)][LOW_MSB:0] ==
      $past(dr_old[LOW_MSB:0]))
      else $error("deselected lower byte altered");
   AST_BURST_SIZE: assert property (
      got <= BURST_LEN && push_idx <= got)
      else $error("write burst exceeds four words");
   AST_ECHO: assert property (
      ek |=> ##1 echo_clock_out)
      else $error("echo clock missed a rising edge");

   COV_READ_HIGH: cover property (rd_cmd && sync2.mode);
   COV_READ_LOW: cover property (rd_cmd && !sync2.mode);
   COV_WRITE_DONE: cover property (wstate == WS_BEAT3 ##1 wstate == WS_IDLE);
   COV_CONCURRENT: cover property (rd_pend && wstate != WS_IDLE);
endmodule

/* verif/qbs_ctrl_model.sv */
// controller model: free running K pair and command, address and data pins
`timescale 1ns/1ps
module qbs_ctrl_model import qbs_pkg::*; (
   input wire logic clk_in,
   input wire logic rstn_in,
   output logic k_out,
   output logic k_n_out,
   output logic rps_n_out,
   output logic wps_n_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic [DATA_W-1:0] d_out,
   output logic [1:0] bws_n_out
);
   logic [4:0] ph; // place in the 20 clk K period (80 ns)
   int cyc;
   int kcyc; // clk count at which the pending K rise (p 0E) or K-bar rise (p 04) happens

   // phase and cycle counters
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ph <= 5'h00;
         cyc <= 0;
      end else begin
         ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
         cyc <= cyc + 1;
      end
   end

   // K-bar rises half a period after K
   assign k_out = (ph < 5'h0A);
   assign k_n_out = ~k_out;

   // both ports deselected until a command is given
   initial begin
      rps_n_out = 1'b1;
      wps_n_out = 1'b1;
      addr_out = 20'h00000;
      d_out = 18'h00000;
      bws_n_out = 2'h3;
   end

   // set pins five clk ahead of the rising edge that samples them;
   // p 0E aims at a K rise, p 04 at a K-bar rise
   task automatic drive(input logic [4:0] p, input logic r, input logic w,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [1:0] b);
      do @(negedge clk_in); while (ph !== p);
      kcyc = cyc + 6;
      @(posedge clk_in);
      rps_n_out <= r;
      wps_n_out <= w;
      addr_out <= a;
      d_out <= d;
      bws_n_out <= b;
   endtask
endmodule

/* verif/quad_rate_burst_sram_port_tb_top.sv */
// self-checking bench of the burst sram port
`timescale 1ns/1ps
module quad_rate_burst_sram_port_tb_top import qbs_pkg::*;;
   typedef struct {logic [DATA_W-1:0] data; int lo; int hi;} qbs_exp_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic mode_pin = 1'b0;
   logic k, k_n, rps_n, wps_n, oe, vld, eck, eck_n, wr_rdy;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d, q;
   logic [1:0] bws_n;
   logic [DATA_W-1:0] mem [int];
   logic [ADDR_W-1:0] pool [8];
   qbs_exp_t exp_q[$];
   logic prev_vld = 1'b0;
   int seed = 34;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;

   always #2 clk = ~clk;

   qbs_ctrl_model ctrl_u (.clk_in(clk), .rstn_in(rstn), .k_out(k),
      .k_n_out(k_n), .rps_n_out(rps_n), .wps_n_out(wps_n),
      .addr_out(addr), .d_out(d), .bws_n_out(bws_n));

   qbs_sram_port #(.MEM_AW(6)) dut_u (.clk_in(clk), .rstn_in(rstn),
      .k_in(k), .k_n_in(k_n), .read_port_select_n_in(rps_n),
      .write_port_select_n_in(wps_n), .addr_in(addr), .d_in(d),
      .byte_write_select_n_in(bws_n), .latency_mode_pin_in(mode_pin),
      .q_out(q), .q_oe_out(oe), .read_valid_flag_out(vld),
      .echo_clock_out(eck), .echo_clock_n_out(eck_n),
      .wr_ready_out(wr_rdy));

   // compare and count
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // byte-gated write of one word over the old contents
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [1:0] b);
      merge = o;
      if (!b[0]) merge[8:0] = n[8:0];
      if (!b[1]) merge[17:9] = n[17:9];
   endfunction

   function automatic int key(input logic [ADDR_W-1:0] a, input int beat);
      key = int'(a[5:0]) * 4 + beat; // array keeps only MEM_AW bits
   endfunction

   // one two-cycle slot with an optional read and an optional write burst
   task automatic slot(input logic rd, input logic [ADDR_W-1:0] ra,
      input logic wr, input logic [ADDR_W-1:0] wa, input logic [7:0] wb);
      logic [4*DATA_W-1:0] wd;
      qbs_exp_t e;
      int lat;
      for (int i = 0; i < 4; i++) wd[i*DATA_W +: DATA_W] = 18'($random(seed));
      lat = (mode_pin ? LAT_HI : LAT_LO) * 10;
      ctrl_u.drive(5'h0E, ~rd, ~wr, ra, wd[17:0], wb[1:0]);
      for (int i = 0; rd && i < 4; i++) begin
         e.data = mem[key(ra, i)];
         e.lo = ctrl_u.kcyc + lat + 2;
         e.hi = (i == 0) ? ctrl_u.kcyc + lat + 25 : 0;
         exp_q.push_back(e);
      end
      for (int i = 0; wr && i < 4; i++) begin
         mem[key(wa, i)] = merge(mem[key(wa, i)], wd[i*DATA_W +: DATA_W],
            wb[2*i +: 2]);
      end
      ctrl_u.drive(5'h04, 1'b1, 1'b1, ra, wd[35:18], wb[3:2]);
      ctrl_u.drive(5'h0E, 1'b1, 1'b1, wa, wd[53:36], wb[5:4]);
      ctrl_u.drive(5'h04, 1'b1, 1'b1, wa, wd[71:54], wb[7:6]);
   endtask

   // deselected slot with junk on data and enabled bytes
   task automatic idle();
      ctrl_u.drive(5'h0E, 1'b1, 1'b1, 20'($random(seed)),
         18'($random(seed)), 2'h0);
      ctrl_u.drive(5'h04, 1'b1, 1'b1, 20'($random(seed)),
         18'($random(seed)), 2'h0);
   endtask

   // output watcher: one valid rise per read word
   always @(negedge clk) begin
      qbs_exp_t e;
      if (rstn) begin
         check("output enable", {31'h0, oe}, {31'h0, vld});
         if (ctrl_u.ph == 5'h05 || ctrl_u.ph == 5'h0F) begin
            check("echo clock", {31'h0, eck}, {31'h0, k});
            check("echo clock n", {31'h0, eck_n}, {31'h0, k_n});
         end
         if (vld === 1'b1 && prev_vld !== 1'b1) begin
            if (exp_q.size() == 0) begin
               check("spare read word", 32'h1, 32'h0);
            end else begin
               e = exp_q.pop_front();
               check("read data", {14'h0, q}, {14'h0, e.data});
               if (e.hi != 0) begin
                  check("read latency", {31'h0, ctrl_u.cyc >= e.lo &&
                     ctrl_u.cyc <= e.hi}, 32'h1);
               end
            end
         end
      end
      prev_vld = vld;
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   // main sequence, both latency modes
   initial begin
      logic [2:0] ia;
      logic [1:0] op;
      for (int i = 0; i < 8; i++) pool[i] = {14'($random(seed)), 6'(i * 9)};
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check("write ready", {31'h0, wr_rdy}, 32'h1);
      for (int m = 0; m < 2; m++) begin
         mode_pin <= m[0];
         repeat (2) @(posedge clk);
         for (int i = 0; i < 8; i++) slot(1'b0, pool[0], 1'b1, pool[i], 8'h00);
         slot(1'b0, pool[0], 1'b1, pool[3], 8'h9C);
         slot(1'b1, pool[3], 1'b0, pool[0], 8'hFF);
         slot(1'b1, pool[1], 1'b1, pool[2], 8'h00);
         slot(1'b1, pool[2], 1'b0, pool[0], 8'hFF);
         idle();
         slot(1'b1, pool[5], 1'b0, pool[0], 8'hFF);
         for (int n = 0; n < 30; n++) begin
            ia = 3'($random(seed));
            op = 2'($random(seed));
            if (op == 2'h0) idle();
            else slot(op[1], pool[ia], op[0], pool[ia + 3'h1],
               8'($random(seed)));
         end
         repeat (300) if (exp_q.size() != 0) @(posedge clk);
         check("words left", exp_q.size(), 32'h0);
      end
      give_verdict();
   end
endmodule
